// ---- logic/rcps_map.svh ----
`ifndef RCPS_MAP_SVH
`define RCPS_MAP_SVH
// -------------------------------------------------------------------------
// Timing
// -------------------------------------------------------------------------
// System clock period in nanoseconds.
`define RCPS_CLK_NS 50
// Shortest reset pulse that must take effect, in nanoseconds.
`define RCPS_RST_PULSE_NS 50
// Cycles of the shortest reset pulse, rounded up, at least one.
`define RCPS_RST_PULSE_CYC ((`RCPS_RST_PULSE_NS + `RCPS_CLK_NS - 1) / `RCPS_CLK_NS)
// Cycles the RC oscillator needs before it counts as running.
`define RCPS_RC_START_CYC 4'h8
// Boot fetch address after reset release.
`define RCPS_BOOT_ADDR 32'h0000_0000
// -------------------------------------------------------------------------
// PLL limits
// -------------------------------------------------------------------------
`define RCPS_MSEL_MIN 6'h01
`define RCPS_MSEL_MAX 6'h20
`define RCPS_PSEL_DEF 2'h0
// -------------------------------------------------------------------------
// Encodings
// -------------------------------------------------------------------------
`define RCPS_CLKO_RC 2'h0
`define RCPS_CLKO_SYS 2'h1
`define RCPS_CLKO_WDT 2'h2
`define RCPS_CLKO_MAIN 2'h3
`define RCPS_PM_SLEEP 3'h1
`define RCPS_PM_DSLEEP 3'h2
`define RCPS_PM_PDOWN 3'h3
`define RCPS_PM_DPD 3'h4
`endif

// ---- logic/rcps_pkg.sv ----
`default_nettype none
package rcps_pkg;
  // Power states of the processor.
  typedef enum logic [2:0] {
    RCPS_ACTIVE,
    RCPS_SLEEP,
    RCPS_DSLEEP,
    RCPS_PDOWN,
    RCPS_DPD
  } rcps_pm_t;
endpackage : rcps_pkg
`default_nettype wire

// ---- logic/rcps_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "rcps_map.svh"
module rcps_top
  import rcps_pkg::*;
(
  input  wire logic        clk_sys,           // System clock, 20 MHz.
  input  wire logic        rst_n,             // Asynchronous reset, active low.
  input  wire logic        reset_pin_n,       // External reset pin, active low.
  input  wire logic        reset_pin_sel,     // Reset function selected on shared pin.
  input  wire logic        wdt_reset,         // Watchdog reset request.
  input  wire logic        por_reset,         // Power-on detector reset.
  input  wire logic        brownout_detector_reset, // Brown-out detector reset.
  input  wire logic        rc_osc_ok,         // RC oscillator running indication.
  input  wire logic        pll_power_req,     // Software request to power the PLL.
  input  wire logic [5:0]  pll_msel_req,      // Requested feedback multiplier.
  input  wire logic [1:0]  pll_psel_req,      // Requested post divider code.
  input  wire logic        pll_locked,        // Lock indication from the PLL.
  input  wire logic        pll_select_req,    // Software selects PLL as main clock.
  input  wire logic        sysosc_en_req,     // Software enables system oscillator.
  input  wire logic        sysosc_stable,     // System oscillator settled.
  input  wire logic [1:0]  clock_output_sel,  // Clock output source select.
  input  wire logic        clk_rc,            // RC oscillator sample.
  input  wire logic        clk_sysosc,        // System oscillator sample.
  input  wire logic        clk_wdt,           // Watchdog oscillator sample.
  input  wire logic        clk_main,          // Main clock sample.
  input  wire logic        pm_enter,          // Pulse: enter the mode below.
  input  wire logic [2:0]  pm_mode,           // Requested reduced-power mode.
  input  wire logic        dpd_lock,          // Lock bit refusing deep power-down.
  input  wire logic        wake_gpio,         // Selected port pin wake.
  input  wire logic        wake_wdt_irq,      // Watchdog interrupt wake.
  input  wire logic        wake_rtc_irq,      // RTC interrupt wake.
  input  wire logic        wake_uart_irq,     // Serial-port interrupt wake.
  input  wire logic        uart_wake_mode,    // Serial port in a wake-capable mode.
  input  wire logic        sleep_irq,         // Any interrupt for sleep exits.
  input  wire logic        deep_sleep_exit_pin, // Wake pin, low requests wake.
  output logic             reset_status_output, // High while internal reset holds.
  output logic             internal_rc_oscillator_en, // RC oscillator enable.
  output logic             flash_init,        // Flash controller init, in reset.
  output logic [31:0]      boot_fetch_addr,   // First fetch address.
  output logic             pll_power,         // PLL powered.
  output logic             pll_bypass,        // PLL bypassed.
  output logic [5:0]       pll_msel,          // Applied multiplier.
  output logic [1:0]       pll_psel,          // Applied post divider code.
  output logic             main_on_pll,       // Main clock runs from PLL.
  output logic             main_on_sysosc,    // Main clock runs from system oscillator.
  output logic             clock_output_pin,  // Selected clock output.
  output logic [2:0]       pm_state,          // Current power state.
  output logic             dpd_refused,       // Pulse: deep power-down refused.
  output logic             core_power_off,    // Core domain unpowered.
  output logic             jtag_sel,          // Boundary scan selected.
  output logic             swd_enable         // Serial-wire debug port enabled.
);

  // -------------------------------------------------------------------------
  // Reset combination
  // -------------------------------------------------------------------------
  logic       rst_hold_ff;   // Internal reset held.
  logic       nxt_rst_hold;
  logic [3:0] rc_cnt_ff;     // RC start-up count.
  logic [3:0] nxt_rc_cnt;
  logic       pin_rst;       // Pin reset request, qualified.
  rcps_pm_t   pm_ff;         // Power state.
  rcps_pm_t   nxt_pm;

  // Pin acts only when selected and not in deep power-down.
  assign pin_rst = reset_pin_sel && !reset_pin_n && (pm_ff != RCPS_DPD);

  // Internal reset is the OR of sources and waits for a running RC.
  // One 50 ns pulse is one cycle, so sampling each edge catches it.
  always_comb
  begin
    nxt_rc_cnt   = rc_cnt_ff;
    nxt_rst_hold = 1'b0;
    if (pin_rst || wdt_reset || por_reset || brownout_detector_reset || !rc_osc_ok)
    begin
      nxt_rc_cnt   = 4'h0;
      nxt_rst_hold = 1'b1;
    end
    else if (rc_cnt_ff != `RCPS_RC_START_CYC)
    begin
      nxt_rc_cnt   = rc_cnt_ff + 4'h1;
      nxt_rst_hold = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_hold_ff <= 1'b1;
      rc_cnt_ff   <= 4'h0;
    end
    else
    begin
      rst_hold_ff <= nxt_rst_hold;
      rc_cnt_ff   <= nxt_rc_cnt;
    end
  end

  // The RC oscillator enable is tied high; reset inits flash, shows status.
  assign internal_rc_oscillator_en = 1'b1;
  assign flash_init                = rst_hold_ff;
  assign reset_status_output       = rst_hold_ff;
  // Fetch starts at the boot vector on release.
  assign boot_fetch_addr           = `RCPS_BOOT_ADDR;

  // -------------------------------------------------------------------------
  // PLL and main clock
  // -------------------------------------------------------------------------
  logic       pll_pwr_ff, nxt_pll_pwr;
  logic [5:0] msel_ff, nxt_msel;
  logic [1:0] psel_ff, nxt_psel;
  logic       on_pll_ff, nxt_on_pll;
  logic       on_sys_ff, nxt_on_sys;

  // Clamp the multiplier to its legal 1..32 range.
  function automatic logic [5:0] rcps_clamp_msel(input logic [5:0] m);
    if (m < `RCPS_MSEL_MIN) return `RCPS_MSEL_MIN;
    if (m > `RCPS_MSEL_MAX) return `RCPS_MSEL_MAX;
    return m;
  endfunction : rcps_clamp_msel

  // Switching to PLL requires power and lock; falls back if lock drops.
  always_comb
  begin
    nxt_pll_pwr = pll_power_req;
    nxt_msel    = rcps_clamp_msel(pll_msel_req);
    nxt_psel    = pll_psel_req;
    nxt_on_pll  = pll_select_req && pll_pwr_ff && pll_locked;
    nxt_on_sys  = sysosc_en_req && sysosc_stable && !nxt_on_pll;
  end

  // Reset leaves the PLL off and bypassed.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pll_pwr_ff <= 1'b0;
      msel_ff    <= `RCPS_MSEL_MIN;
      psel_ff    <= `RCPS_PSEL_DEF;
      on_pll_ff  <= 1'b0;
      on_sys_ff  <= 1'b0;
    end
    else if (rst_hold_ff)
    begin
      pll_pwr_ff <= 1'b0;
      msel_ff    <= `RCPS_MSEL_MIN;
      psel_ff    <= `RCPS_PSEL_DEF;
      on_pll_ff  <= 1'b0;
      on_sys_ff  <= 1'b0;
    end
    else
    begin
      pll_pwr_ff <= nxt_pll_pwr;
      msel_ff    <= nxt_msel;
      psel_ff    <= nxt_psel;
      on_pll_ff  <= nxt_on_pll;
      on_sys_ff  <= nxt_on_sys;
    end
  end

  // The two-bit code gives only 2, 4, 8 or 16, so duty stays even.
  assign pll_power      = pll_pwr_ff;
  assign pll_bypass     = !on_pll_ff;
  assign pll_msel       = msel_ff;
  assign pll_psel       = psel_ff;
  assign main_on_pll    = on_pll_ff;
  assign main_on_sysosc = on_sys_ff;

  // -------------------------------------------------------------------------
  // Clock output
  // -------------------------------------------------------------------------
  logic clko_ff, nxt_clko;

  // One of four sources is registered onto the pin.
  always_comb
  begin
    unique case (clock_output_sel)
      `RCPS_CLKO_RC:   nxt_clko = clk_rc;
      `RCPS_CLKO_SYS:  nxt_clko = clk_sysosc;
      `RCPS_CLKO_WDT:  nxt_clko = clk_wdt;
      `RCPS_CLKO_MAIN: nxt_clko = clk_main;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      clko_ff <= 1'b0;
    else
      clko_ff <= nxt_clko;
  end

  assign clock_output_pin = clko_ff;

  // -------------------------------------------------------------------------
  // Power modes
  // -------------------------------------------------------------------------
  logic refuse_ff, nxt_refuse;
  logic pd_wake;

  // Serial-port wake counts only in a wake-capable mode.
  assign pd_wake = pin_rst || wake_gpio || wake_wdt_irq || wake_rtc_irq ||
                   (wake_uart_irq && uart_wake_mode);

  // Four reduced states; lock refuses deep power-down.
  always_comb
  begin
    nxt_pm     = pm_ff;
    nxt_refuse = 1'b0;
    unique case (pm_ff)
      RCPS_ACTIVE:
        if (pm_enter)
        begin
          unique case (pm_mode)
            `RCPS_PM_SLEEP:  nxt_pm = RCPS_SLEEP;
            `RCPS_PM_DSLEEP: nxt_pm = RCPS_DSLEEP;
            `RCPS_PM_PDOWN:  nxt_pm = RCPS_PDOWN;
            `RCPS_PM_DPD:
              if (dpd_lock)
                nxt_refuse = 1'b1;
              else
                nxt_pm = RCPS_DPD;
            default:         nxt_pm = RCPS_ACTIVE;
          endcase
        end
      RCPS_SLEEP:
        if (sleep_irq || pin_rst) nxt_pm = RCPS_ACTIVE;
      RCPS_DSLEEP:
        if (sleep_irq || pin_rst) nxt_pm = RCPS_ACTIVE;
      RCPS_PDOWN:
        if (pd_wake) nxt_pm = RCPS_ACTIVE;
      RCPS_DPD:
        // Only a low wake pin or an RTC wake ends it.
        if (!deep_sleep_exit_pin || wake_rtc_irq) nxt_pm = RCPS_ACTIVE;
      // Codes above deep power-down are unused; fall back to active.
      default: nxt_pm = RCPS_ACTIVE;
    endcase
    // Any chip reset ends the reduced states, except deep power-down,
    // where the sources are unpowered and only the wake paths count.
    if (rst_hold_ff && (pm_ff != RCPS_DPD))
      nxt_pm = RCPS_ACTIVE;
  end

  // Registers only; rst_n is the sole asynchronous clear of the power state.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pm_ff     <= RCPS_ACTIVE;
      refuse_ff <= 1'b0;
    end
    else
    begin
      pm_ff     <= nxt_pm;
      refuse_ff <= nxt_refuse;
    end
  end

  assign pm_state       = pm_ff;
  assign dpd_refused    = refuse_ff;
  assign core_power_off = (pm_ff == RCPS_DPD);

  // -------------------------------------------------------------------------
  // Debug port select
  // -------------------------------------------------------------------------
  // Low pin selects boundary scan, high selects SWD; SWD off in reset.
  assign jtag_sel   = !reset_pin_n;
  assign swd_enable = reset_pin_n && !rst_hold_ff;

  // -------------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------------
  chk_rst_src_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wdt_reset || por_reset || brownout_detector_reset) |=> reset_status_output)
    else $error("Reset source did not hold internal reset.");
  chk_rst_release: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(reset_status_output) |-> $past(rc_osc_ok, 2))
    else $error("Reset released without running RC oscillator.");
  chk_pin_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!reset_pin_n && reset_pin_sel && pm_ff != RCPS_DPD) |=> reset_status_output)
    else $error("Short reset pulse was missed.");
  chk_pll_off_rst: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reset_status_output |=> (!pll_power && pll_bypass))
    else $error("PLL active after reset.");
  chk_msel_range: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pll_msel >= `RCPS_MSEL_MIN && pll_msel <= `RCPS_MSEL_MAX))
    else $error("PLL multiplier out of range.");
  chk_pll_lock_sel: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(main_on_pll) |-> $past(pll_locked))
    else $error("PLL selected without lock.");
  chk_dpd_lock: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pm_ff == RCPS_ACTIVE && pm_enter && pm_mode == `RCPS_PM_DPD && dpd_lock)
      |=> (dpd_refused && pm_ff == RCPS_ACTIVE))
    else $error("Deep power-down entered while locked.");
  chk_dpd_wake: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pm_ff == RCPS_DPD && deep_sleep_exit_pin && !wake_rtc_irq)
      |=> pm_ff == RCPS_DPD)
    else $error("Deep power-down left without wake.");
  chk_swd_reset: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reset_status_output |-> !swd_enable)
    else $error("SWD enabled during reset.");
  chk_rst_pm_wake: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (reset_status_output && pm_ff != RCPS_DPD) |=> pm_ff == RCPS_ACTIVE)
    else $error("Reduced-power state kept through chip reset.");

endmodule : rcps_top
`default_nettype wire

// ---- test/rcps_board.sv ----
`timescale 1ns/1ns
`default_nettype none
// -------------------------------------------------------------------------
// Board model of the reset pin and the wake pin
// -------------------------------------------------------------------------
module rcps_board
(
  input  wire logic rst_low,             // Bench asks for the reset pin low.
  input  wire logic wake_low,            // Bench asks for the wake pin low.
  output wire logic reset_pin_n,         // Reset pin, pulled high when not driven.
  output wire logic deep_sleep_exit_pin  // Wake pin, pulled high when not driven.
);
  // The pull-up keeps the reset pin high unless the tester pulls it low.
  assign reset_pin_n = rst_low ? 1'b0 : 1'b1;
  // The wake pin rests high and goes low only to ask for wake-up.
  assign deep_sleep_exit_pin = wake_low ? 1'b0 : 1'b1;
endmodule : rcps_board
`default_nettype wire

// ---- test/testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "rcps_map.svh"
module testbench;
  import rcps_pkg::*;
  // -----------------------------------------------------------------------
  // Signals
  // -----------------------------------------------------------------------
  logic clk_sys = 1'b0, rst_n, reset_pin_sel, wdt_reset, por_reset, rc_osc_ok;
  logic brownout_detector_reset;        // Brown-out detector reset request.
  logic pll_power_req, pll_locked, pll_select_req, sysosc_en_req, sysosc_stable, pm_enter;
  logic dpd_lock, wake_gpio, wake_wdt_irq, wake_rtc_irq, wake_uart_irq, uart_wake_mode;
  logic sleep_irq, clk_rc, clk_sysosc, clk_wdt, clk_main, rst_low, wake_low;
  logic [5:0] pll_msel_req, pll_msel;   // Multiplier request and result.
  logic [1:0] pll_psel_req, pll_psel, clock_output_sel; // Divider and clock output select.
  logic [2:0] pm_mode, pm_state;        // Power mode request and state.
  logic [31:0] boot_fetch_addr;         // First fetch address.
  logic reset_status_output, internal_rc_oscillator_en, flash_init, pll_power, pll_bypass;
  logic main_on_pll, main_on_sysosc, clock_output_pin, dpd_refused, core_power_off;
  logic jtag_sel, swd_enable;           // Test port selection.
  wire logic reset_pin_n, deep_sleep_exit_pin; // Pins driven by the board model.
  int error_cnt = 0;                    // Mismatches seen.
  int comparisons = 0;                  // Comparisons made.

  always #25 clk_sys = ~clk_sys;

  rcps_board board (.rst_low, .wake_low, .reset_pin_n, .deep_sleep_exit_pin);
  rcps_top DUT (.clk_sys, .rst_n, .reset_pin_n, .reset_pin_sel, .wdt_reset, .por_reset,
    .brownout_detector_reset, .rc_osc_ok, .pll_power_req, .pll_msel_req, .pll_psel_req,
    .pll_locked, .pll_select_req, .sysosc_en_req, .sysosc_stable, .clock_output_sel,
    .clk_rc, .clk_sysosc,
    .clk_wdt, .clk_main, .pm_enter, .pm_mode, .dpd_lock, .wake_gpio, .wake_wdt_irq,
    .wake_rtc_irq, .wake_uart_irq, .uart_wake_mode, .sleep_irq, .deep_sleep_exit_pin,
    .reset_status_output, .internal_rc_oscillator_en, .flash_init, .boot_fetch_addr,
    .pll_power, .pll_bypass, .pll_msel, .pll_psel, .main_on_pll, .main_on_sysosc,
    .clock_output_pin, .pm_state, .dpd_refused, .core_power_off, .jtag_sel, .swd_enable);

  // -----------------------------------------------------------------------
  // Tasks
  // -----------------------------------------------------------------------
  // Case equality keeps an unknown from passing as a match.
  task automatic check_bit(input string nm, input logic exp, input logic got);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %b seen %b", nm, exp, got);
    end
  endtask : check_bit
  task automatic check_vec(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : check_vec
  task automatic end_sim;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  // All stimulus moves on the falling edge, away from the sampling edge.
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick
  // Waits a bounded time for the internal reset to let go.
  task automatic wait_rel;
    for (int i = 0; i < 30 && reset_status_output !== 1'b0; i++)
      tick(1);
    check_bit("release", 1'b0, reset_status_output);
  endtask : wait_rel
  // One-cycle request for a reduced-power mode.
  task automatic pm_go(input logic [2:0] m);
    pm_enter = 1'b1;
    pm_mode = m;
    tick(1);
    pm_enter = 1'b0;
  endtask : pm_go
  // Pulses one wake or reset input word for one cycle, then settles.
  task automatic pulse5(input logic [4:0] v);
    {wake_gpio, wake_wdt_irq, wake_rtc_irq, wake_uart_irq, rst_low} = v;
    tick(1);
    {wake_gpio, wake_wdt_irq, wake_rtc_irq, wake_uart_irq, rst_low} = 5'h00;
    tick(1);
  endtask : pulse5

  // -----------------------------------------------------------------------
  // Watchdog: about forty thousand cycles, far beyond the tests.
  // -----------------------------------------------------------------------
  initial
  begin
    #2000000;
    error_cnt++;
    end_sim();
  end

  // -----------------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------------
  initial
  begin
    {wdt_reset, por_reset, brownout_detector_reset, pll_power_req, pll_locked} = '0;
    pll_select_req = 1'b0;
    {sysosc_en_req, sysosc_stable, pm_enter, dpd_lock, wake_gpio, wake_wdt_irq} = '0;
    {wake_rtc_irq, wake_uart_irq, uart_wake_mode, sleep_irq, clk_rc, clk_sysosc} = '0;
    {clk_wdt, clk_main, rst_low, wake_low, pll_msel_req, pll_psel_req, clock_output_sel} = '0;
    {pm_mode, rst_n, reset_pin_sel, rc_osc_ok} = 6'b000_011;
    tick(2);
    rst_n = 1'b1;
    check_bit("status", 1'b1, reset_status_output);
    wait_rel();
    check_bit("pll_power", 1'b0, pll_power);
    check_bit("pll_bypass", 1'b1, pll_bypass);
    check_vec("boot", `RCPS_BOOT_ADDR, boot_fetch_addr);
    check_bit("rc_en", 1'b1, internal_rc_oscillator_en);
    check_bit("swd", 1'b1, swd_enable);
    // Each source alone, held one cycle, which is the shortest pin pulse.
    for (int i = 0; i < 4; i++)
    begin
      {rst_low, wdt_reset, por_reset, brownout_detector_reset} = 4'b1000 >> i;
      tick(1);
      {rst_low, wdt_reset, por_reset, brownout_detector_reset} = 4'h0;
      check_bit("status", 1'b1, reset_status_output);
      check_bit("flash_init", 1'b1, flash_init);
      check_bit("swd", 1'b0, swd_enable);
      tick(4);
      check_bit("hold", 1'b1, reset_status_output);
      wait_rel();
    end
    // A stopped RC oscillator keeps the chip in reset.
    rc_osc_ok = 1'b0;
    por_reset = 1'b1;
    tick(1);
    por_reset = 1'b0;
    tick(20);
    check_bit("rc_hold", 1'b1, reset_status_output);
    rc_osc_ok = 1'b1;
    wait_rel();
    // A pin given to another function does not reset.
    reset_pin_sel = 1'b0;
    pulse5(5'h01);
    check_bit("unselected", 1'b0, reset_status_output);
    reset_pin_sel = 1'b1;
    // PLL: selection is refused while powered but unlocked; the multiplier clamps at both ends.
    pll_select_req = 1'b1;
    pll_power_req = 1'b1;
    pll_psel_req = 2'h3;
    tick(2);
    check_bit("pll_power", 1'b1, pll_power);
    check_bit("no_lock", 1'b0, main_on_pll);
    check_vec("msel_lo", `RCPS_MSEL_MIN, pll_msel);
    check_vec("psel", 2'h3, pll_psel);
    pll_locked = 1'b1;
    pll_msel_req = 6'h28;
    tick(2);
    check_bit("on_pll", 1'b1, main_on_pll);
    check_bit("bypass", 1'b0, pll_bypass);
    check_vec("msel_hi", `RCPS_MSEL_MAX, pll_msel);
    // Requests stay up through a watchdog reset; reset alone must stop the PLL.
    wdt_reset = 1'b1;
    tick(1);
    wdt_reset = 1'b0;
    wait_rel();
    check_bit("pll_off", 1'b0, pll_power);
    check_bit("pll_byp", 1'b1, pll_bypass);
    {pll_select_req, pll_power_req, pll_locked} = 3'h0;
    // System oscillator is used only once it has settled.
    sysosc_en_req = 1'b1;
    tick(2);
    check_bit("sysosc_wait", 1'b0, main_on_sysosc);
    sysosc_stable = 1'b1;
    tick(2);
    check_bit("sysosc_on", 1'b1, main_on_sysosc);
    // Clock output: only the chosen source is high, then only it is low.
    for (int s = 0; s < 4; s++)
    begin
      clock_output_sel = 2'(s);
      {clk_main, clk_wdt, clk_sysosc, clk_rc} = 4'b0001 << s;
      tick(2);
      check_bit("clock_output_hi", 1'b1, clock_output_pin);
      {clk_main, clk_wdt, clk_sysosc, clk_rc} = ~(4'b0001 << s);
      tick(2);
      check_bit("clock_output_lo", 1'b0, clock_output_pin);
    end
    // Sleep and deep-sleep leave on an interrupt.
    for (int m = 1; m < 3; m++)
    begin
      pm_go(3'(m));
      check_vec("pm_enter", 3'(m), pm_state);
      sleep_irq = 1'b1;
      tick(1);
      sleep_irq = 1'b0;
      tick(1);
      check_vec("pm_wake", 3'h0, pm_state);
    end
    // An unused mode code leaves the part active.
    pm_go(3'h5);
    check_vec("pm_bad", 3'h0, pm_state);
    // Power-down: each listed wake event, the pin reset last.
    uart_wake_mode = 1'b1;
    for (int k = 0; k < 5; k++)
    begin
      pm_go(`RCPS_PM_PDOWN);
      check_vec("pdown", `RCPS_PM_PDOWN, pm_state);
      pulse5(5'b10000 >> k);
      check_vec("pdown_wake", 3'h0, pm_state);
    end
    wait_rel();
    uart_wake_mode = 1'b0;
    pm_go(`RCPS_PM_PDOWN);
    pulse5(5'h02);
    check_vec("uart_nomode", `RCPS_PM_PDOWN, pm_state);
    // A watchdog chip reset also ends power-down.
    wdt_reset = 1'b1;
    tick(1);
    wdt_reset = 1'b0;
    tick(1);
    check_vec("pdown_rst", 3'h0, pm_state);
    wait_rel();
    // Deep power-down refused while the lock is set.
    dpd_lock = 1'b1;
    pm_go(`RCPS_PM_DPD);
    check_bit("refused", 1'b1, dpd_refused);
    check_vec("no_dpd", 3'h0, pm_state);
    tick(1);
    check_bit("refused_end", 1'b0, dpd_refused);
    dpd_lock = 1'b0;
    // Deep power-down: pin reset, gpio and sleep interrupts do nothing.
    pm_go(`RCPS_PM_DPD);
    check_vec("dpd", `RCPS_PM_DPD, pm_state);
    check_bit("core_off", 1'b1, core_power_off);
    rst_low = 1'b1;
    #1;
    check_bit("jtag", 1'b1, jtag_sel);
    tick(1);
    rst_low = 1'b0;
    sleep_irq = 1'b1;
    pulse5(5'h10);
    sleep_irq = 1'b0;
    check_vec("dpd_stay", `RCPS_PM_DPD, pm_state);
    check_bit("dpd_norst", 1'b0, reset_status_output);
    wake_low = 1'b1;
    tick(1);
    wake_low = 1'b0;
    tick(1);
    check_vec("wake_pin", 3'h0, pm_state);
    check_bit("core_on", 1'b0, core_power_off);
    pm_go(`RCPS_PM_DPD);
    pulse5(5'h04);
    check_vec("wake_rtc", 3'h0, pm_state);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
